// ---- rgbls_pin_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module rgbls_pin_model (
   // clock
   input wire logic        pclk,
   // stimulus control
   input wire logic        tog,
   input wire logic [15:0] half,
   input wire logic        level,
   // device side of the pin
   input wire logic        dev_out,
   input wire logic        dev_oe_n,
   output logic            pin
);
   logic [15:0] cnt_r;
   logic        drv_r;
   initial begin
      cnt_r = 16'h0;
      drv_r = 1'b0;
   end
   // a held level serves as gate, a toggle as reference clock
   always @(posedge pclk) begin
      if (!tog) begin
         cnt_r <= 16'h0;
         drv_r <= level;
      end else if (cnt_r == half - 16'h1) begin
         cnt_r <= 16'h0;
         drv_r <= !drv_r;
      end else begin
         cnt_r <= cnt_r + 16'h1;
      end
   end
   // the device owns the wire only while its enable is low
   assign pin = dev_oe_n ? drv_r : dev_out;
endmodule // rgbls_pin_model
`default_nettype wire

// ---- rgbls_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module rgbls_props (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // pin and channels
   input wire logic        clk_pwm_in,
   input wire logic        clk_pwm_out,
   input wire logic        clk_pwm_oe_n,
   input wire logic [2:0]  led_out
);
   logic [1:0] pin_r;
   logic       on0_r;
   logic       wr_ctrl;
   logic       mapped;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign wr_ctrl = psel && penable && pready && pwrite && paddr == 8'h00;
   assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
   // shadow of the control fields, taken where the write lands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_r <= 2'h0;
         on0_r <= 1'b0;
      end else if (wr_ctrl) begin
         pin_r <= pwdata[9:8];
         on0_r <= pwdata[0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence acc_s;
      psel && penable;
   endsequence
   apb_answer_a: assert property (setup_s ##1 acc_s |-> pready)
      else $error("access not answered in its first cycle");
   err_flag_a: assert property ((acc_s and (pready && !mapped)) |-> pslverr)
      else $error("unmapped access without error");
   wr_rdata_a: assert property ((acc_s and (pready && pwrite)) |-> prdata == 32'h0)
      else $error("read data not zero on a write");
   pwm_gate_a: assert property ((pin_r == 2'h1 && !clk_pwm_in)[*5] |-> led_out == 3'h0)
      else $error("output on while gate pin low");
   pin_drive_a: assert property (wr_ctrl && pwdata[9:8] == 2'h3 |-> ##[1:2] !clk_pwm_oe_n)
      else $error("pin not driven in clock out mode");
   pin_release_a: assert property ((pin_r != 2'h3)[*3] |-> clk_pwm_oe_n)
      else $error("pin driven outside clock out mode");
   pin_off_a: assert property ((pin_r == 2'h0)[*3] |-> !clk_pwm_out)
      else $error("pin output active in off mode");
   off_stop_a: assert property (wr_ctrl && !pwdata[0] |-> ##[1:3] !led_out[0])
      else $error("channel output not stopped");
   on_delay_a: assert property (wr_ctrl && pwdata[0] && !on0_r |-> ##1 !led_out[0] [*8])
      else $error("channel lit before its delay");
endmodule // rgbls_props
bind rgbls_top rgbls_props props_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .clk_pwm_in, .clk_pwm_out, .clk_pwm_oe_n, .led_out);
`default_nettype wire

// ---- rgbls_regs.vh ----
`ifndef RGBLS_REGS_VH
`define RGBLS_REGS_VH

// apb register byte offsets
`define RGBLS_CTRL      8'h00
`define RGBLS_STAT      8'h04
`define RGBLS_DUTY      8'h08
`define RGBLS_CFGA0     8'h10
`define RGBLS_CFGB0     8'h14
`define RGBLS_CFGA1     8'h18
`define RGBLS_CFGB1     8'h1c
`define RGBLS_CFGA2     8'h20
`define RGBLS_CFGB2     8'h24

// control register fields
`define RGBLS_ON_LSB    0
`define RGBLS_MODE_LSB  4
`define RGBLS_PIN_LSB   8

// config a fields (4 bits each)
`define RGBLS_FLOOR_LSB 0
`define RGBLS_MID_LSB   4
`define RGBLS_CEIL_LSB  8
`define RGBLS_DLY_LSB   12
`define RGBLS_RISE_LSB  16
`define RGBLS_FALL_LSB  20

// reset values
`define RGBLS_CTRL_RST  10'h000
`define RGBLS_CFGA_RST  24'h000000
`define RGBLS_CFGB_RST  16'h8888

// clock_pwm_pin modes
`define RGBLS_PIN_OFF   2'h0
`define RGBLS_PIN_EPWM  2'h1
`define RGBLS_PIN_ECLK  2'h2
`define RGBLS_PIN_ICLK  2'h3

// timing
`define RGBLS_PCLK_HZ   200000000
`define RGBLS_REF_HZ    2400000
`define RGBLS_DIV_CNT   (`RGBLS_PCLK_HZ / `RGBLS_REF_HZ)
`define RGBLS_STEP_TCK  2400
`define RGBLS_TOTAL_TCK 1200000
`define RGBLS_DLY_TCK   1200000

`endif

// ---- rgbls_top.v ----
`timescale 1ns/100ps
`default_nettype none
`include "rgbls_regs.vh"

module rgbls_top #(
   parameter [31:0] STEP_TCK  = `RGBLS_STEP_TCK,
   parameter [31:0] TOTAL_TCK = `RGBLS_TOTAL_TCK,
   parameter [31:0] DLY_TCK   = `RGBLS_DLY_TCK
) (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // shared clock / pwm pin
   input  wire        clk_pwm_in,
   output reg         clk_pwm_out,
   output reg         clk_pwm_oe_n,
   // channel outputs
   output reg  [2:0]  led_out
);

   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_DELAY = 3'h1;
   localparam [2:0] ST_CONST = 3'h2;
   localparam [2:0] ST_PH1   = 3'h3;
   localparam [2:0] ST_PH2   = 3'h4;
   localparam [2:0] ST_PH3   = 3'h5;
   localparam [2:0] ST_PH4   = 3'h6;
   localparam [31:0] DIV_LAST_W = `RGBLS_DIV_CNT - 1;
   localparam [31:0] DIV_HALF_W = `RGBLS_DIV_CNT / 2;
   localparam [6:0]  DIV_LAST   = DIV_LAST_W[6:0];
   localparam [6:0]  DIV_HALF   = DIV_HALF_W[6:0];

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // register select: 0 ctrl, 1 stat, 2 duty, 3..8 cfg a/b per channel, 15 none
   function [3:0] reg_sel;
      input [7:0] a;
      begin
         case (a)
            `RGBLS_CTRL:  reg_sel = 4'h0;
            `RGBLS_STAT:  reg_sel = 4'h1;
            `RGBLS_DUTY:  reg_sel = 4'h2;
            `RGBLS_CFGA0: reg_sel = 4'h3;
            `RGBLS_CFGB0: reg_sel = 4'h4;
            `RGBLS_CFGA1: reg_sel = 4'h5;
            `RGBLS_CFGB1: reg_sel = 4'h6;
            `RGBLS_CFGA2: reg_sel = 4'h7;
            `RGBLS_CFGB2: reg_sel = 4'h8;
            default:      reg_sel = 4'hf;
         endcase
      end
   endfunction

   // 4-bit level code to 7-bit duty; upper levels fill the low bits
   function [6:0] duty_map;
      input [3:0] code;
      input       top;
      begin
         duty_map = {code, top ? 3'h7 : 3'h0};
      end
   endfunction

   // tick limit of a 4-bit code, never below one tick
   function [31:0] tck_lim;
      input [3:0]  code;
      input [31:0] unit;
      reg   [35:0] p;
      begin
         p = code * unit;
         tck_lim = (p == 36'h0) ? 32'h1 : p[31:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // registers

   reg  [9:0]  ctrl_r;
   reg  [23:0] cfga_r [0:2];
   reg  [15:0] cfgb_r [0:2];
   wire [2:0]  ch_on   = ctrl_r[`RGBLS_ON_LSB +: 3];
   wire [2:0]  ch_mode = ctrl_r[`RGBLS_MODE_LSB +: 3];
   wire [1:0]  pin_md  = ctrl_r[`RGBLS_PIN_LSB +: 2];
   wire [2:0]  st_w [0:2];
   wire [6:0]  duty_w [0:2];
   wire [2:0]  led_nxt;
   wire        wr_en   = psel & penable & pready & pwrite;
   wire [3:0]  sel     = reg_sel(paddr);
   reg  [31:0] rd_nxt;
   integer     i;

   always @* begin
      case (sel)
         4'h0:    rd_nxt = {22'h0, ctrl_r};
         4'h1:    rd_nxt = {21'h0, st_w[2], 1'b0, st_w[1], 1'b0, st_w[0]};
         4'h2:    rd_nxt = {9'h0, duty_w[2], 1'b0, duty_w[1], 1'b0, duty_w[0]};
         4'h3:    rd_nxt = {8'h0, cfga_r[0]};
         4'h4:    rd_nxt = {16'h0, cfgb_r[0]};
         4'h5:    rd_nxt = {8'h0, cfga_r[1]};
         4'h6:    rd_nxt = {16'h0, cfgb_r[1]};
         4'h7:    rd_nxt = {8'h0, cfga_r[2]};
         4'h8:    rd_nxt = {16'h0, cfgb_r[2]};
         default: rd_nxt = 32'h0;
      endcase
   end

   // one wait-free access phase: pready rises the cycle after setup
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & (sel == 4'hf);
         if (psel & ~penable)
            prdata <= pwrite ? 32'h0 : rd_nxt;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `RGBLS_CTRL_RST;
         for (i = 0; i < 3; i = i + 1) begin
            cfga_r[i] <= `RGBLS_CFGA_RST;
            cfgb_r[i] <= `RGBLS_CFGB_RST;
         end
      end else if (wr_en) begin
         case (sel)
            4'h0:    ctrl_r    <= pwdata[9:0];
            4'h3:    cfga_r[0] <= pwdata[23:0];
            4'h4:    cfgb_r[0] <= pwdata[15:0];
            4'h5:    cfga_r[1] <= pwdata[23:0];
            4'h6:    cfgb_r[1] <= pwdata[15:0];
            4'h7:    cfga_r[2] <= pwdata[23:0];
            4'h8:    cfgb_r[2] <= pwdata[15:0];
            default: ctrl_r    <= ctrl_r;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reference tick and shared pin

   reg  [6:0] div_r;
   reg        pin_q_r;
   reg        tick_r;
   reg  [6:0] pwm_cnt_r;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r        <= 7'h00;
         pin_q_r      <= 1'b0;
         tick_r       <= 1'b0;
         pwm_cnt_r    <= 7'h00;
         clk_pwm_out  <= 1'b0;
         clk_pwm_oe_n <= 1'b1;
         led_out      <= 3'h0;
      end else begin
         led_out <= led_nxt;
         div_r   <= (div_r == DIV_LAST) ? 7'h00 : div_r + 7'h01;
         pin_q_r <= clk_pwm_in;
         // external reference replaces the divider; a stopped source stalls timing
         if (pin_md == `RGBLS_PIN_ECLK)
            tick_r <= clk_pwm_in & ~pin_q_r;
         else
            tick_r <= (div_r == DIV_LAST);
         if (tick_r)
            pwm_cnt_r <= pwm_cnt_r + 7'h01;
         clk_pwm_oe_n <= (pin_md != `RGBLS_PIN_ICLK);
         clk_pwm_out  <= (pin_md == `RGBLS_PIN_ICLK) & (div_r < DIV_HALF);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // channel sequencers

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : gch
         reg  [2:0]  st_r;
         reg  [6:0]  duty_r;
         reg  [31:0] hold_r;
         reg  [31:0] tot_r;
         reg         mode_q_r;
         wire [23:0] ca    = cfga_r[g];
         wire [15:0] cb    = cfgb_r[g];
         wire [6:0]  d_flr = duty_map(ca[`RGBLS_FLOOR_LSB +: 4], 1'b0);
         wire [6:0]  d_mid = duty_map(ca[`RGBLS_MID_LSB +: 4], 1'b1);
         wire [6:0]  d_cei = duty_map(ca[`RGBLS_CEIL_LSB +: 4], 1'b1);
         wire [3:0]  rise  = ca[`RGBLS_RISE_LSB +: 4];
         wire [3:0]  fall  = ca[`RGBLS_FALL_LSB +: 4];
         wire [1:0]  ph    = st_r[1:0] - 2'h3;
         wire [31:0] h_lim = tck_lim(cb[ph*4 +: 4], STEP_TCK);
         wire        up    = (st_r == ST_PH1) | (st_r == ST_PH2);
         wire [6:0]  tgt   = (st_r == ST_PH1) ? d_mid :
                             (st_r == ST_PH2) ? d_cei :
                             (st_r == ST_PH3) ? d_mid : d_flr;
         wire        in_rs = up & (rise != 4'h0);
         wire        in_fl = ~up & (fall != 4'h0);
         // a zero total code leaves the ramp unbounded
         wire        t_hit = (in_rs & (tot_r + 32'h1 >= tck_lim(rise, TOTAL_TCK))) |
                             (in_fl & (tot_r + 32'h1 >= tck_lim(fall, TOTAL_TCK)));
         wire        h_hit = (hold_r + 32'h1 >= h_lim);
         wire        more  = up ? (duty_r < tgt) : (duty_r > tgt);

         assign st_w[g]   = st_r;
         assign duty_w[g] = duty_r;
         // pwm period is 128 ticks; duty 127 leaves one low tick
         assign led_nxt[g] = ((st_r == ST_CONST) |
                              ((st_r >= ST_PH1) & (pwm_cnt_r < duty_r))) &
                             ((pin_md != `RGBLS_PIN_EPWM) | clk_pwm_in);

         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               st_r     <= ST_IDLE;
               duty_r   <= 7'h00;
               hold_r   <= 32'h0;
               tot_r    <= 32'h0;
               mode_q_r <= 1'b0;
            end else begin
               mode_q_r <= ch_mode[g];
               // off or a mode change drops back to idle
               if (!ch_on[g] || (mode_q_r != ch_mode[g])) begin
                  st_r   <= ST_IDLE;
                  duty_r <= 7'h00;
                  hold_r <= 32'h0;
                  tot_r  <= 32'h0;
               end else if (tick_r) begin
                  case (st_r)
                     ST_IDLE: begin
                        st_r   <= ST_DELAY;
                        hold_r <= 32'h0;
                     end
                     ST_DELAY: begin
                        if (ca[`RGBLS_DLY_LSB +: 4] == 4'h0 ||
                            hold_r + 32'h1 >= tck_lim(ca[`RGBLS_DLY_LSB +: 4], DLY_TCK)) begin
                           hold_r <= 32'h0;
                           tot_r  <= 32'h0;
                           duty_r <= d_flr;
                           st_r   <= ch_mode[g] ? ST_PH1 : ST_CONST;
                        end else begin
                           hold_r <= hold_r + 32'h1;
                        end
                     end
                     ST_CONST: st_r <= ST_CONST;
                     ST_PH1, ST_PH2, ST_PH3, ST_PH4: begin
                        tot_r <= tot_r + 32'h1;
                        if (t_hit) begin
                           hold_r <= 32'h0;
                           tot_r  <= 32'h0;
                           st_r   <= up ? ST_PH3 : ST_PH1;
                           duty_r <= up ? d_cei : d_flr;
                        end else if (h_hit) begin
                           hold_r <= 32'h0;
                           if (more) begin
                              duty_r <= up ? duty_r + 7'h01 : duty_r - 7'h01;
                           end else begin
                              // flat phase when start is already at the target
                              case (st_r)
                                 ST_PH1: begin
                                    st_r   <= ST_PH2;
                                    duty_r <= d_mid;
                                 end
                                 ST_PH2: begin
                                    st_r   <= ST_PH3;
                                    duty_r <= d_cei;
                                    tot_r  <= 32'h0;
                                 end
                                 ST_PH3: begin
                                    st_r   <= ST_PH4;
                                    duty_r <= d_mid;
                                 end
                                 default: begin
                                    st_r   <= ST_PH1;
                                    duty_r <= d_flr;
                                    tot_r  <= 32'h0;
                                 end
                              endcase
                           end
                        end else begin
                           hold_r <= hold_r + 32'h1;
                        end
                     end
                     default: st_r <= ST_IDLE;
                  endcase
               end
            end
         end
      end
   endgenerate

endmodule // rgbls_top
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        clk_pwm_in, clk_pwm_out, clk_pwm_oe_n, tog, level, err_v;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic [2:0]  led_out, cur;
   logic [15:0] half;
   int          comparisons, n_fail, cycles, n;
   rgbls_top #(.STEP_TCK(32'd2), .TOTAL_TCK(32'd40), .DLY_TCK(32'd4)) dut_u (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .clk_pwm_in,
      .clk_pwm_out, .clk_pwm_oe_n, .led_out);
   rgbls_pin_model pin_u (.pclk, .tog, .half, .level, .dev_out(clk_pwm_out),
      .dev_oe_n(clk_pwm_oe_n), .pin(clk_pwm_in));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task finish_test;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         n_fail = n_fail + 1;
         finish_test;
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("register", rd_v, e);
   endtask
   task automatic wled(input int ch, input logic v, input int lim);
      for (n = 0; n < lim && led_out[ch] !== v; n++) @(posedge pclk);
      chk("led", 32'(led_out[ch]), 32'(v));
   endtask
   // wait for the next phase of channel one, then check entry duty
   task automatic stp(input logic [2:0] es, input logic [6:0] ed);
      apb(1'b0, 8'h04, 32'h0);
      for (n = 0; n < 9000 && rd_v[6:4] === cur; n++) apb(1'b0, 8'h04, 32'h0);
      cur = rd_v[6:4];
      chk("state", 32'(cur), 32'(es));
      rd(8'h08, {17'h0, ed, 8'h0});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, tog, level, cur} = '0;
      paddr = 8'h0;
      pwdata = 32'h0;
      half = 16'd10;
      presetn = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(8'h00, 32'h0);
      rd(8'h14, 32'h8888);
      apb(1'b1, 8'h0c, 32'hffffffff);
      chk("error", 32'(err_v), 32'h1);
      rd(8'h0c, 32'h0);
      apb(1'b1, 8'h04, 32'hffffffff);
      rd(8'h04, 32'h0);
      apb(1'b1, 8'h10, 32'h1000);
      rd(8'h10, 32'h1000);
      apb(1'b1, 8'h00, 32'h1);
      repeat (200) @(posedge pclk);
      chk("led early", 32'(led_out[0]), 32'h0);
      wled(0, 1'b1, 600);
      rd(8'h04, 32'h2);
      apb(1'b1, 8'h00, 32'h0);
      rd(8'h04, 32'h0);
      chk("led off", 32'(led_out[0]), 32'h0);
      apb(1'b1, 8'h18, 32'hf52);
      apb(1'b1, 8'h1c, 32'h0);
      apb(1'b1, 8'h00, 32'h22);
      stp(3'h1, 7'd0);
      stp(3'h3, 7'd16);
      stp(3'h4, 7'd47);
      stp(3'h5, 7'd127);
      wled(1, 1'b1, 300);
      stp(3'h6, 7'd47);
      stp(3'h3, 7'd16);
      apb(1'b1, 8'h00, 32'h0);
      cur = 3'h0;
      apb(1'b1, 8'h18, 32'h110f52);
      apb(1'b1, 8'h1c, 32'h1);
      apb(1'b1, 8'h00, 32'h22);
      stp(3'h1, 7'd0);
      stp(3'h3, 7'd16);
      stp(3'h5, 7'd127);
      stp(3'h3, 7'd16);
      apb(1'b1, 8'h10, 32'h0);
      apb(1'b1, 8'h00, 32'h101);
      level <= 1'b1;
      wled(0, 1'b1, 400);
      repeat (5000) @(posedge pclk);
      level <= 1'b0;
      wled(0, 1'b0, 8);
      apb(1'b1, 8'h00, 32'h200);
      apb(1'b1, 8'h00, 32'h201);
      repeat (400) @(posedge pclk);
      chk("led stalled", 32'(led_out[0]), 32'h0);
      tog <= 1'b1;
      wled(0, 1'b1, 200);
      apb(1'b1, 8'h00, 32'h300);
      @(posedge pclk);
      chk("pin enable", 32'(clk_pwm_oe_n), 32'h0);
      for (n = 0; n < 400 && clk_pwm_out !== 1'b1; n++) @(posedge pclk);
      chk("clock out", 32'(clk_pwm_out), 32'h1);
      apb(1'b1, 8'h00, 32'h0);
      repeat (4) @(posedge pclk);
      chk("pin off", 32'({clk_pwm_oe_n, clk_pwm_out}), 32'h2);
      finish_test;
   end
endmodule // tb_top
`default_nettype wire
